/* File: ltm_params.svh */
// offsets, field positions, reset values and timing counts of the tolerance timer block
`ifndef LTM_PARAMS_SVH
`define LTM_PARAMS_SVH

// register byte offsets
`define LTM_OFS_IDLE_FAST 8'hE0
`define LTM_OFS_IDLE_SLOW 8'hE4
`define LTM_OFS_ACT_FAST 8'hE8
`define LTM_OFS_ACT_SLOW 8'hEC
`define LTM_OFS_INACT_FAST 8'hF0
`define LTM_OFS_INACT_SLOW 8'hF4
`define LTM_OFS_CONTROL 8'hF8
`define LTM_OFS_STATUS 8'hFC

// field positions
`define LTM_BELT_W 12
`define LTM_BELT_FAST_LSB 16
`define LTM_BELT_SLOW_LSB 0
`define LTM_RELOAD_W 16
`define LTM_RELOAD_FAST_LSB 16
`define LTM_RELOAD_SLOW_LSB 0
`define LTM_CTRL_ENABLE_BIT 0
`define LTM_STAT_COUNT_LSB 0
`define LTM_STAT_BELT_LSB 16
`define LTM_STAT_IDLE_BIT 28
`define LTM_STAT_COUNTING_BIT 29
`define LTM_STAT_SPEED_LSB 30

// writable bits of each register; bus writes clear reserved bits, an image load or restore stores them unmasked
`define LTM_MASK_BELT_PAIR 32'h0FFF_0FFF
`define LTM_MASK_BELT_ONE 32'h0000_0FFF
`define LTM_MASK_RELOAD_PAIR 32'hFFFF_FFFF
`define LTM_MASK_RELOAD_ONE 32'h0000_FFFF
`define LTM_MASK_CONTROL 32'h0000_0001

// reset values when no image was loaded
`define LTM_RESET_WORD 32'h0000_0000
`define LTM_RESET_CONTROL 32'h0000_0000

// timing: one timer unit and the core clock rate
`define LTM_TICK_US 100
`define LTM_CLK_MHZ 10
`define LTM_TICK_CYCLES (`LTM_TICK_US * `LTM_CLK_MHZ)

`endif

/* File: ltm_pkg.sv */
// types shared by the tolerance timer block
package ltm_pkg;

  typedef enum logic [1:0] {
    speed_10m = 2'h0,
    speed_100m = 2'h1,
    speed_gig = 2'h2
  } link_speed_t;

  // gray along busy -> counting -> idle
  typedef enum logic [1:0] {
    st_busy = 2'h0,
    st_counting = 2'h1,
    st_idle = 2'h3
  } tol_state_t;

  typedef struct packed {
    logic [31:0] idle_tolerance_fast;
    logic [31:0] idle_tolerance_slow;
    logic [31:0] active_tolerance_fast;
    logic [31:0] active_tolerance_slow;
    logic [31:0] inactivity_reload_fast;
    logic [31:0] inactivity_reload_slow;
  } ltm_image_t;

  typedef struct packed {
    logic usb_bound_empty;
    logic usb_inbound_empty;
    logic eth_receive_empty;
    logic eth_transmit_empty;
    logic bulk_out_pending;
  } activity_t;

  typedef struct packed {
    logic valid;
    logic idle;
    logic [11:0] belt;
  } ltm_msg_t;

endpackage : ltm_pkg

/* File: ltm_tick_divider.sv */
// divider that makes the one-cycle timer unit pulse from the core clock
`include "ltm_params.svh"

module ltm_tick_divider #(
  parameter int unsigned CYCLES = `LTM_TICK_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic restart,
  output logic tick
);
  localparam int unsigned W = (CYCLES > 1) ? $clog2(CYCLES) : 1;

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic tick_w;

  // restart realigns the unit so the first decrement after a load is a full unit
  always_comb begin
    tick_w = (cnt_q == W'(CYCLES - 1));
    if (restart || tick_w) begin
      cnt_d = '0;
    end else begin
      cnt_d = W'(cnt_q + 1'b1);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign tick = tick_w && !restart;

endmodule : ltm_tick_divider

/* File: ltm_belt_timer.sv */
// latency tolerance inactivity timer and tolerance value selection
//
// The implementer's own choice: the plain strobed port.
`include "ltm_params.svh"

module ltm_belt_timer #(
  parameter int unsigned TICK_CYCLES = `LTM_TICK_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic usb_reset,
  input wire logic lite_reset,
  input wire logic image_load,
  input wire ltm_pkg::ltm_image_t image,
  input wire ltm_pkg::link_speed_t link_speed,
  input wire ltm_pkg::activity_t activity,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic [11:0] belt_value,
  output logic tolerance_idle,
  output ltm_pkg::ltm_msg_t ltm_msg
);
  import ltm_pkg::*;

  ltm_image_t cfg_q;
  ltm_image_t cfg_d;
  ltm_image_t shadow_q;
  ltm_image_t shadow_d;
  logic enable_q;
  logic enable_d;
  tol_state_t state_q;
  tol_state_t state_d;
  logic [15:0] count_q;
  logic [15:0] count_d;
  logic [11:0] belt_q;
  logic [11:0] belt_d;
  logic [11:0] belt_sel;
  logic [15:0] reload_sel;
  logic [2:0] key_now;
  logic [2:0] key_last_q;
  ltm_msg_t msg_q;
  ltm_msg_t msg_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [31:0] status_word;
  logic quiet;
  logic tick;
  logic load;
  logic is_idle;

  // unit pulse; a load realigns it
  ltm_tick_divider #(
    .CYCLES(TICK_CYCLES)
  ) u_tick (
    .clock(clock),
    .rst(rst),
    .restart(load),
    .tick(tick)
  );

  // all four fifos empty, nothing pending on bulk out, and the feature on
  assign quiet = enable_q && activity.usb_bound_empty && activity.usb_inbound_empty
    && activity.eth_receive_empty && activity.eth_transmit_empty
    && !activity.bulk_out_pending;
  assign is_idle = (state_q == st_idle);

  // reload value picked by link speed; the unused code falls back to 10M
  always_comb begin
    case (link_speed)
      speed_gig: begin
        reload_sel = cfg_q.inactivity_reload_fast[`LTM_RELOAD_FAST_LSB +: `LTM_RELOAD_W];
      end
      speed_100m: begin
        reload_sel = cfg_q.inactivity_reload_fast[`LTM_RELOAD_SLOW_LSB +: `LTM_RELOAD_W];
      end
      default: begin
        reload_sel = cfg_q.inactivity_reload_slow[`LTM_RELOAD_SLOW_LSB +: `LTM_RELOAD_W];
      end
    endcase
  end

  // tolerance value for the current state and speed
  always_comb begin
    case (link_speed)
      speed_gig: begin
        belt_sel = is_idle ? cfg_q.idle_tolerance_fast[`LTM_BELT_FAST_LSB +: `LTM_BELT_W]
          : cfg_q.active_tolerance_fast[`LTM_BELT_FAST_LSB +: `LTM_BELT_W];
      end
      speed_100m: begin
        belt_sel = is_idle ? cfg_q.idle_tolerance_fast[`LTM_BELT_SLOW_LSB +: `LTM_BELT_W]
          : cfg_q.active_tolerance_fast[`LTM_BELT_SLOW_LSB +: `LTM_BELT_W];
      end
      default: begin
        belt_sel = is_idle ? cfg_q.idle_tolerance_slow[`LTM_BELT_SLOW_LSB +: `LTM_BELT_W]
          : cfg_q.active_tolerance_slow[`LTM_BELT_SLOW_LSB +: `LTM_BELT_W];
      end
    endcase
  end

  // inactivity state machine; any activity wins over an expiry in the same cycle
  always_comb begin
    state_d = state_q;
    count_d = count_q;
    load = 1'b0;
    case (state_q)
      st_busy: begin
        if (quiet) begin
          load = 1'b1;
          count_d = reload_sel;
          state_d = st_counting;
        end
      end
      st_counting: begin
        if (!quiet) begin
          state_d = st_busy;
        end else if (count_q == 16'h0000) begin
          state_d = st_idle;
        end else if (tick) begin
          count_d = 16'(count_q - 16'h0001);
        end
      end
      st_idle: begin
        if (!quiet) begin
          state_d = st_busy;
        end
      end
      default: begin
        state_d = st_busy;
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= st_busy;
      count_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      count_q <= count_d;
    end
  end

  // message on each entry to or exit from idle and each change of speed, carrying the value now in force
  assign key_now = {is_idle, link_speed};
  always_comb begin
    belt_d = belt_sel;
    msg_d = '0;
    if (key_now != key_last_q) begin
      msg_d.valid = 1'b1;
      msg_d.idle = is_idle;
      msg_d.belt = belt_sel;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      belt_q <= 12'h000;
      msg_q <= '0;
      key_last_q <= 3'h0;
    end else begin
      belt_q <= belt_d;
      msg_q <= msg_d;
      key_last_q <= key_now;
    end
  end

  assign belt_value = belt_q;
  assign tolerance_idle = is_idle;
  assign ltm_msg = msg_q;

  // configuration: image load beats a restore, a restore beats a bus write
  always_comb begin
    shadow_d = shadow_q;
    cfg_d = cfg_q;
    enable_d = enable_q;
    if (image_load) begin
      shadow_d = image;
      cfg_d = image;
    end else if (usb_reset || lite_reset) begin
      cfg_d = shadow_q;
    end else if (reg_wr) begin
      case (reg_addr)
        `LTM_OFS_IDLE_FAST: begin
          cfg_d.idle_tolerance_fast = reg_wdata & `LTM_MASK_BELT_PAIR;
        end
        `LTM_OFS_IDLE_SLOW: begin
          cfg_d.idle_tolerance_slow = reg_wdata & `LTM_MASK_BELT_ONE;
        end
        `LTM_OFS_ACT_FAST: begin
          cfg_d.active_tolerance_fast = reg_wdata & `LTM_MASK_BELT_PAIR;
        end
        `LTM_OFS_ACT_SLOW: begin
          cfg_d.active_tolerance_slow = reg_wdata & `LTM_MASK_BELT_ONE;
        end
        `LTM_OFS_INACT_FAST: begin
          cfg_d.inactivity_reload_fast = reg_wdata & `LTM_MASK_RELOAD_PAIR;
        end
        `LTM_OFS_INACT_SLOW: begin
          cfg_d.inactivity_reload_slow = reg_wdata & `LTM_MASK_RELOAD_ONE;
        end
        `LTM_OFS_CONTROL: begin
          enable_d = reg_wdata[`LTM_CTRL_ENABLE_BIT];
        end
        default: begin
          enable_d = enable_q;
        end
      endcase
    end
  end

  // image shadow starts at zero so an absent image restores to zero
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      shadow_q <= {6{`LTM_RESET_WORD}};
      cfg_q <= {6{`LTM_RESET_WORD}};
      enable_q <= 1'b0;
    end else begin
      shadow_q <= shadow_d;
      cfg_q <= cfg_d;
      enable_q <= enable_d;
    end
  end

  // read data stand only in the cycle after the strobe, zero otherwise
  always_comb begin
    status_word = '0;
    status_word[`LTM_STAT_COUNT_LSB +: 16] = count_q;
    status_word[`LTM_STAT_BELT_LSB +: `LTM_BELT_W] = belt_q;
    status_word[`LTM_STAT_IDLE_BIT] = is_idle;
    status_word[`LTM_STAT_COUNTING_BIT] = (state_q == st_counting);
    status_word[`LTM_STAT_SPEED_LSB +: 2] = link_speed;
    rdata_d = '0;
    if (reg_rd) begin
      case (reg_addr)
        `LTM_OFS_IDLE_FAST: rdata_d = cfg_q.idle_tolerance_fast;
        `LTM_OFS_IDLE_SLOW: rdata_d = cfg_q.idle_tolerance_slow;
        `LTM_OFS_ACT_FAST: rdata_d = cfg_q.active_tolerance_fast;
        `LTM_OFS_ACT_SLOW: rdata_d = cfg_q.active_tolerance_slow;
        `LTM_OFS_INACT_FAST: rdata_d = cfg_q.inactivity_reload_fast;
        `LTM_OFS_INACT_SLOW: rdata_d = cfg_q.inactivity_reload_slow;
        `LTM_OFS_CONTROL: rdata_d = {31'h0000_0000, enable_q};
        `LTM_OFS_STATUS: rdata_d = status_word;
        default: rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // helper: cycles since the last unit pulse or realignment
  logic [15:0] gap_q;
  logic [15:0] gap_d;
  localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);
  always_comb begin
    gap_d = (tick || load) ? 16'h0000 : 16'(gap_q + 16'h0001);
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      gap_q <= 16'h0000;
    end else begin
      gap_q <= gap_d;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  a_idle_slow_belt: assert property (
    (is_idle && link_speed == speed_10m) |=> belt_value == $past(cfg_q.idle_tolerance_slow[11:0]))
    else $error("idle 10M tolerance value wrong");

  a_active_gig_belt: assert property (
    (!is_idle && link_speed == speed_gig) |=> belt_value == $past(cfg_q.active_tolerance_fast[27:16]))
    else $error("active gig tolerance value wrong");

  a_active_100m_belt: assert property (
    (!is_idle && link_speed == speed_100m) |=> belt_value == $past(cfg_q.active_tolerance_fast[11:0]))
    else $error("active 100M tolerance value wrong");

  a_active_10m_belt: assert property (
    (!is_idle && link_speed == speed_10m) |=> belt_value == $past(cfg_q.active_tolerance_slow[11:0]))
    else $error("active 10M tolerance value wrong");

  a_idle_fast_belt: assert property (
    (is_idle && link_speed == speed_gig) |=> belt_value == $past(cfg_q.idle_tolerance_fast[27:16]))
    else $error("idle gig tolerance value wrong");

  a_load_gig_reload: assert property (
    (state_q == st_busy && quiet && link_speed == speed_gig)
      |=> state_q == st_counting && count_q == $past(cfg_q.inactivity_reload_fast[31:16]))
    else $error("gig timer load wrong");

  a_load_100m_reload: assert property (
    (state_q == st_busy && quiet && link_speed == speed_100m)
      |=> state_q == st_counting && count_q == $past(cfg_q.inactivity_reload_fast[15:0]))
    else $error("100M timer load wrong");

  a_load_10m_reload: assert property (
    (state_q == st_busy && quiet && link_speed == speed_10m)
      |=> state_q == st_counting && count_q == $past(cfg_q.inactivity_reload_slow[15:0]))
    else $error("10M timer load wrong");

  a_no_load_busy: assert property (
    (state_q == st_busy && !quiet) |=> state_q == st_busy)
    else $error("timer loaded while not quiet");

  a_expire_to_idle: assert property (
    (state_q == st_counting && quiet && count_q == 16'h0000) |=> is_idle)
    else $error("zero count did not enter idle");

  a_tick_unit: assert property (
    (tick && state_q == st_counting && quiet && count_q != 16'h0000)
      |-> gap_q == TICK_LAST ##1 count_q == $past(count_q) - 16'h0001)
    else $error("timer unit spacing or decrement wrong");

  a_lite_restore: assert property (
    ((usb_reset || lite_reset) && !image_load) |=> cfg_q == $past(shadow_q))
    else $error("reset did not restore image values");

  a_activity_wakes: assert property (
    (!quiet && state_q != st_busy) |=> state_q == st_busy ##1 !is_idle)
    else $error("activity did not return to active");

  a_msg_on_change: assert property (
    (key_now != key_last_q) |=> ltm_msg.valid && ltm_msg.belt == belt_value && ltm_msg.idle == $past(is_idle))
    else $error("tolerance message missing on change");

  c_enter_idle: cover property (state_q == st_counting ##1 is_idle);
  c_wake_idle: cover property (is_idle ##1 state_q == st_busy);
  c_restore: cover property (lite_reset && !image_load);
  c_speed_msg: cover property ($changed(link_speed) ##1 ltm_msg.valid);

endmodule : ltm_belt_timer

/* File: ltm_host_model.sv */
// host-side model that latches each latency tolerance message
module ltm_host_model (
  input wire logic clock,
  input wire logic rst,
  input wire ltm_pkg::ltm_msg_t msg,
  output logic [11:0] last_belt,
  output logic last_idle,
  output logic [15:0] msg_cnt
);
  import ltm_pkg::*;

  // the host never acknowledges, so a message is only seen in its one valid cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      last_belt <= 12'h000;
      last_idle <= 1'b0;
      msg_cnt <= 16'h0000;
    end else if (msg.valid) begin
      last_belt <= msg.belt;
      last_idle <= msg.idle;
      msg_cnt <= msg_cnt + 16'h0001;
    end
  end
endmodule : ltm_host_model

/* File: test_ltm_belt_timer.sv */
// self-checking bench for the latency tolerance timer
`include "ltm_params.svh"
module test_ltm_belt_timer;
  timeunit 1ns;
  timeprecision 1ns;
  import ltm_pkg::*;

  typedef struct {link_speed_t spd; logic [15:0] rl; logic [11:0] act; logic [11:0] idl;} row_t;

  // short unit so an expiry takes tens of cycles, not thousands
  localparam int TICK = 4;
  logic clock;
  logic rst = 1'b1;
  logic usb_reset = 1'b0;
  logic lite_reset = 1'b0;
  logic image_load = 1'b0;
  ltm_image_t image = '0;
  link_speed_t link_speed = speed_10m;
  activity_t activity = 5'h0E;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [11:0] belt_value;
  logic tolerance_idle;
  ltm_msg_t ltm_msg;
  logic [11:0] last_belt;
  logic last_idle;
  logic [15:0] msg_cnt;
  int error_cnt = 0;
  int comparisons = 0;
  int i;
  int n;
  logic [31:0] v;
  row_t rows [3];
  // register table: offset, written word, expected read after masking
  logic [7:0] ofs [6] = '{`LTM_OFS_IDLE_FAST, `LTM_OFS_IDLE_SLOW, `LTM_OFS_ACT_FAST,
    `LTM_OFS_ACT_SLOW, `LTM_OFS_INACT_FAST, `LTM_OFS_INACT_SLOW};
  logic [31:0] wv [6] = '{32'hFAAA_FBBB, 32'hFFFF_FCCC, 32'hF111_F222, 32'hFFFF_F333,
    32'h0003_0002, 32'hABCD_0001};
  logic [31:0] rv [6] = '{32'h0AAA_0BBB, 32'h0000_0CCC, 32'h0111_0222, 32'h0000_0333,
    32'h0003_0002, 32'h0000_0001};

  ltm_belt_timer #(.TICK_CYCLES(TICK)) uut (.clock(clock), .rst(rst), .usb_reset(usb_reset),
    .lite_reset(lite_reset), .image_load(image_load), .image(image), .link_speed(link_speed),
    .activity(activity), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .belt_value(belt_value),
    .tolerance_idle(tolerance_idle), .ltm_msg(ltm_msg));

  ltm_host_model host (.clock(clock), .rst(rst), .msg(ltm_msg), .last_belt(last_belt),
    .last_idle(last_idle), .msg_cnt(msg_cnt));

  // 10 MHz core clock
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  task print_verdict;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : print_verdict

  // a hang costs no more than this span, which is more than twenty times the run
  initial begin
    #(5000 * 100);
    error_cnt++;
    print_verdict();
  end

  // main sequence
  initial begin
    rows[0] = '{speed_10m, 16'h0001, 12'h333, 12'hCCC};
    rows[1] = '{speed_100m, 16'h0002, 12'h222, 12'hBBB};
    rows[2] = '{speed_gig, 16'h0003, 12'h111, 12'hAAA};
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    for (i = 0; i < 6; i++) begin
      rd(ofs[i], v);
      check(v, 32'h0000_0000);
    end
    for (i = 0; i < 6; i++) begin
      wr(ofs[i], wv[i]);
      rd(ofs[i], v);
      check(v, rv[i]);
    end
    rd(8'h00, v);
    check(v, 32'h0000_0000);
    @(posedge clock);
    #1 check(reg_rdata, 32'h0000_0000);
    wr(`LTM_OFS_CONTROL, 32'h0000_0001);
    for (i = 0; i < 3; i++) begin
      @(posedge clock);
      activity <= 5'h0E;
      link_speed <= rows[i].spd;
      repeat (3) @(posedge clock);
      #1 check(32'(belt_value), 32'(rows[i].act));
      @(posedge clock);
      activity <= 5'h1E;
      rd(`LTM_OFS_STATUS, v);
      check(32'(v[15:0]), 32'(rows[i].rl));
      n = 2;
      while (tolerance_idle !== 1'b1 && n < 200) begin
        @(posedge clock);
        #1 n++;
      end
      check(32'(n >= TICK * rows[i].rl && n <= TICK * rows[i].rl + 3), 32'h1);
      repeat (2) @(posedge clock);
      #1 check(32'(belt_value), 32'(rows[i].idl));
      check(32'({last_idle, last_belt}), 32'({1'b1, rows[i].idl}));
      check(32'(msg_cnt), 32'(3 * i + 1));
      @(posedge clock);
      activity <= 5'h1F;
      repeat (3) @(posedge clock);
      #1 check(32'({tolerance_idle, belt_value}), 32'(rows[i].act));
      check(32'({last_idle, last_belt}), 32'(rows[i].act));
      check(32'(msg_cnt), 32'(3 * i + 2));
    end
    // the unused speed code falls back to the 10M values
    @(posedge clock);
    link_speed <= link_speed_t'(2'h3);
    repeat (3) @(posedge clock);
    #1 check(32'(belt_value), 32'(rows[0].act));
    // activity in mid-count must abort the countdown, not let it expire
    @(posedge clock);
    link_speed <= speed_gig;
    activity <= 5'h1E;
    repeat (6) @(posedge clock);
    activity <= 5'h1F;
    repeat (3 * TICK) @(posedge clock);
    rd(`LTM_OFS_STATUS, v);
    check(32'({tolerance_idle, v[29:28]}), 32'h0);
    // with the enable off a quiet datapath must never count down
    wr(`LTM_OFS_CONTROL, 32'h0000_0000);
    @(posedge clock);
    activity <= 5'h1E;
    repeat (20) @(posedge clock);
    rd(`LTM_OFS_STATUS, v);
    check(32'({tolerance_idle, v[29:28]}), 32'h0);
    // image shadow restored by both soft resets
    @(posedge clock);
    image.active_tolerance_fast <= 32'h0444_0555;
    image.inactivity_reload_slow <= 32'h0000_1234;
    image_load <= 1'b1;
    @(posedge clock);
    image_load <= 1'b0;
    rd(`LTM_OFS_ACT_FAST, v);
    check(v, 32'h0444_0555);
    wr(`LTM_OFS_ACT_FAST, 32'h0666_0777);
    wr(`LTM_OFS_INACT_SLOW, 32'h0000_5678);
    @(posedge clock);
    usb_reset <= 1'b1;
    @(posedge clock);
    usb_reset <= 1'b0;
    rd(`LTM_OFS_ACT_FAST, v);
    check(v, 32'h0444_0555);
    wr(`LTM_OFS_INACT_SLOW, 32'h0000_5678);
    @(posedge clock);
    lite_reset <= 1'b1;
    @(posedge clock);
    lite_reset <= 1'b0;
    rd(`LTM_OFS_INACT_SLOW, v);
    check(v, 32'h0000_1234);
    print_verdict();
  end
endmodule : test_ltm_belt_timer
